// *** design/branch_skip_compare_exec.sv ***
// execution unit for compare, skip, flag branch and data load instructions
//
// Implementation choices: register access over AXI4-Lite and the address map.
`timescale 1ns/100ps
`default_nettype none
// Overview of operation
// RULE1 - equal compare skip: matching registers skip next
// RULE2 - compares subtract, set six flags, one cycle
// RULE3 - register bit skip on clear or set
// RULE4 - io bit skip, one extra cycle
// RULE5 - flag branch: pc plus offset plus one
// RULE6 - zero and carry branch conditions
// RULE7 - signed branches use negative xor overflow
// RULE8 - half carry and transfer bit branches
// RULE9 - overflow and negative flag branches
// RULE10 - interrupt enable flag branches
// RULE11 - direct load reads constant address, two cycles
// RULE12 - post increment load: read then pointer plus one
// RULE13 - pre decrement load: pointer minus one, read
// RULE14 - skip two or three words by length
module branch_skip_compare_exec import bsc_pkg::*; #(
	parameter int PC_W = 16,
	parameter int ADDR_W = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// instruction from fetch
	input wire logic ex_valid,
	input wire logic [4:0] ex_op,
	input wire logic [2:0] ex_sel,
	input wire logic [6:0] ex_offset,
	input wire logic [7:0] ex_imm,
	input wire logic [15:0] ex_addr,
	input wire logic [4:0] ex_rd_idx,
	input wire logic ex_next_long,
	output logic ex_ready,
	output logic [PC_W-1:0] pc,
	output logic [7:0] status_flags,
	// register file and pointer pair
	input wire logic [7:0] rd_data,
	input wire logic [7:0] rr_data,
	input wire logic [15:0] ex_ptr,
	output logic rf_we,
	output logic [4:0] rf_idx,
	output logic [7:0] rf_data,
	output logic ptr_we,
	output logic [15:0] ptr_data,
	// data space
	input wire logic [7:0] io_data,
	output logic mem_req,
	output logic [15:0] mem_addr,
	input wire logic mem_ack,
	input wire logic [7:0] mem_rdata,
	// axi4-lite slave
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready
);
	// sign extension of the offset needs eight bits, the register read path at most 32
	if (PC_W < 8 || PC_W > 32 || ADDR_W < 4) begin : g_bad_params
		$error("unsupported PC_W or ADDR_W");
	end

	// ----------------------------------------
	// state
	// ----------------------------------------
	typedef struct packed {
		state_t st;
		logic [1:0] cnt;
		logic load_pend;
		logic ptr_inc;
		logic en;
		logic [PC_W-1:0] pc;
		logic [7:0] flags;
		logic rdy;
		logic rf_we;
		logic [4:0] rf_idx;
		logic [7:0] rf_data;
		logic ptr_we;
		logic [15:0] ptr_data;
		logic mem_req;
		logic [15:0] mem_addr;
		logic aw_got;
		logic [ADDR_W-1:0] aw_addr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_all_t;

	state_all_t s_r, s_nxt;
	logic rstn_meta_r, rstn_sync_r;
	logic take;
	logic [PC_W-1:0] br_target;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	// 0..3 for the four words, 4 for an unmapped address
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		reg_sel = 3'h4;
		if ((a >> 4) == '0 && a[1:0] == 2'h0) begin
			reg_sel = {1'b0, a[3:2]};
		end
	endfunction : reg_sel

	function automatic logic is_branch(input logic [4:0] op);
		is_branch = (op >= OP_FLAG_SET_BR) && (op <= OP_ID_BR);
	endfunction : is_branch

	function automatic logic branch_taken(input logic [4:0] op, input logic [2:0] sel,
			input logic [7:0] f);
		case (op)
			OP_FLAG_SET_BR: branch_taken = f[sel]; // RULE5
			OP_FLAG_CLR_BR: branch_taken = ~f[sel]; // RULE5
			OP_EQ_BR: branch_taken = f[FLAG_Z]; // RULE6
			OP_NE_BR: branch_taken = ~f[FLAG_Z]; // RULE6
			OP_CS_BR, OP_LO_BR: branch_taken = f[FLAG_C]; // RULE6
			OP_CC_BR, OP_SH_BR: branch_taken = ~f[FLAG_C]; // RULE6
			OP_GE_BR: branch_taken = ~(f[FLAG_N] ^ f[FLAG_V]); // RULE7
			OP_LT_BR: branch_taken = f[FLAG_N] ^ f[FLAG_V]; // RULE7
			OP_HS_BR: branch_taken = f[FLAG_H]; // RULE8
			OP_HC_BR: branch_taken = ~f[FLAG_H]; // RULE8
			OP_TS_BR: branch_taken = f[FLAG_T]; // RULE8
			OP_TC_BR: branch_taken = ~f[FLAG_T]; // RULE8
			OP_VS_BR: branch_taken = f[FLAG_V]; // RULE9
			OP_VC_BR: branch_taken = ~f[FLAG_V]; // RULE9
			OP_MI_BR: branch_taken = f[FLAG_N]; // RULE9
			OP_PL_BR: branch_taken = ~f[FLAG_N]; // RULE9
			OP_IE_BR: branch_taken = f[FLAG_I]; // RULE10
			OP_ID_BR: branch_taken = ~f[FLAG_I]; // RULE10
			default: branch_taken = 1'b0;
		endcase
	endfunction : branch_taken

	// subtract with no write-back; chained compare keeps zero only if it was set
	function automatic logic [7:0] cmp_flags(input logic [7:0] a, input logic [7:0] b,
			input logic cin, input logic chain, input logic [7:0] f);
		logic [7:0] r;
		logic [7:0] o;
		r = a - b - {7'h00, cin};
		o = f;
		o[FLAG_H] = (~a[3] & b[3]) | (b[3] & r[3]) | (r[3] & ~a[3]);
		o[FLAG_C] = (~a[7] & b[7]) | (b[7] & r[7]) | (r[7] & ~a[7]);
		o[FLAG_V] = (a[7] & ~b[7] & ~r[7]) | (~a[7] & b[7] & r[7]);
		o[FLAG_N] = r[7];
		o[FLAG_S] = o[FLAG_N] ^ o[FLAG_V];
		o[FLAG_Z] = (r == 8'h00) & (~chain | f[FLAG_Z]);
		cmp_flags = o;
	endfunction : cmp_flags

	assign take = ex_valid && s_r.rdy && (s_r.st == ST_IDLE);
	assign br_target = s_r.pc + {{(PC_W-7){ex_offset[6]}}, ex_offset} + PC_W'(1); // RULE5

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		logic skip;
		logic [1:0] extra;
		skip = 1'b0;
		extra = 2'h0;
		s_nxt = s_r;
		s_nxt.rf_we = 1'b0;
		s_nxt.ptr_we = 1'b0;
		// register writes land first so execution in the same cycle overrides them
		if (s_r.aw_got && s_r.w_got && !s_r.bvalid) begin
			s_nxt.aw_got = 1'b0;
			s_nxt.w_got = 1'b0;
			s_nxt.bvalid = 1'b1;
			s_nxt.bresp = RESP_OKAY;
			case (reg_sel(s_r.aw_addr))
				3'(OFS_CTRL >> 2): if (s_r.wstrb[0]) s_nxt.en = s_r.wdata[CTRL_EN_BIT];
				3'(OFS_FLAGS >> 2): if (s_r.wstrb[0]) s_nxt.flags = s_r.wdata[7:0];
				3'(OFS_PC >> 2): begin
					for (int i = 0; i < PC_W; i++) begin
						if (s_r.wstrb[i/8]) s_nxt.pc[i] = s_r.wdata[i];
					end
				end
				3'(OFS_STATE >> 2): s_nxt.bresp = RESP_OKAY;
				default: s_nxt.bresp = RESP_SLVERR;
			endcase
		end
		if (s_axi_awvalid && s_r.awready) begin
			s_nxt.aw_got = 1'b1;
			s_nxt.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_r.wready) begin
			s_nxt.w_got = 1'b1;
			s_nxt.wdata = s_axi_wdata;
			s_nxt.wstrb = s_axi_wstrb;
		end
		if (s_r.bvalid && s_axi_bready) s_nxt.bvalid = 1'b0;
		s_nxt.awready = !s_nxt.aw_got && !s_nxt.bvalid;
		s_nxt.wready = !s_nxt.w_got && !s_nxt.bvalid;
		if (s_r.rvalid && s_axi_rready) s_nxt.rvalid = 1'b0;
		if (s_axi_arvalid && s_r.arready) begin
			s_nxt.rvalid = 1'b1;
			s_nxt.rresp = RESP_OKAY;
			case (reg_sel(s_axi_araddr))
				3'(OFS_CTRL >> 2): s_nxt.rdata = {31'h0, s_r.en};
				3'(OFS_FLAGS >> 2): s_nxt.rdata = {24'h0, s_r.flags};
				3'(OFS_PC >> 2): s_nxt.rdata = 32'(s_r.pc);
				3'(OFS_STATE >> 2): s_nxt.rdata = {28'h0, s_r.mem_req, s_r.st, ~s_r.rdy};
				default: begin
					s_nxt.rdata = 32'h0;
					s_nxt.rresp = RESP_SLVERR;
				end
			endcase
		end
		s_nxt.arready = !s_nxt.rvalid;

		case (s_r.st)
			ST_IDLE: begin
				s_nxt.rdy = s_nxt.en;
				if (take) begin
					s_nxt.pc = s_r.pc + PC_W'(1);
					s_nxt.load_pend = 1'b0;
					s_nxt.ptr_inc = 1'b0;
					s_nxt.rf_idx = ex_rd_idx;
					case (ex_op)
						OP_EQ_SKIP: skip = (rd_data == rr_data); // RULE1
						OP_CMP: s_nxt.flags = cmp_flags(rd_data, rr_data, 1'b0, 1'b0,
								s_nxt.flags); // RULE2
						OP_CMP_C: s_nxt.flags = cmp_flags(rd_data, rr_data, s_r.flags[FLAG_C],
								1'b1, s_nxt.flags); // RULE2
						OP_CMP_I: s_nxt.flags = cmp_flags(rd_data, ex_imm, 1'b0, 1'b0,
								s_nxt.flags); // RULE2
						OP_RBIT_CLR_SKIP: skip = ~rr_data[ex_sel]; // RULE3
						OP_RBIT_SET_SKIP: skip = rr_data[ex_sel]; // RULE3
						OP_IOBIT_CLR_SKIP, OP_IOBIT_SET_SKIP: begin
							skip = io_data[ex_sel] ^ (ex_op == OP_IOBIT_CLR_SKIP); // RULE4
							extra = IO_SKIP_ADD; // RULE4
						end
						OP_DIRECT_LOAD: begin
							s_nxt.pc = s_r.pc + PC_W'(2);
							s_nxt.mem_addr = ex_addr; // RULE11
							s_nxt.load_pend = 1'b1;
							extra = DIRECT_LOAD_EXTRA; // RULE11
						end
						OP_IND_LOAD, OP_IND_LOAD_INC: begin
							s_nxt.mem_addr = ex_ptr;
							s_nxt.ptr_inc = (ex_op == OP_IND_LOAD_INC); // RULE12
							s_nxt.mem_req = 1'b1;
							s_nxt.st = ST_LOAD;
						end
						OP_IND_LOAD_DEC: begin
							s_nxt.ptr_we = 1'b1;
							s_nxt.ptr_data = ex_ptr - 16'h0001; // RULE13
							s_nxt.mem_addr = ex_ptr - 16'h0001; // RULE13
							s_nxt.load_pend = 1'b1;
							extra = DEC_LOAD_EXTRA; // RULE13
						end
						default: begin
							if (is_branch(ex_op) && branch_taken(ex_op, ex_sel, s_r.flags)) begin
								s_nxt.pc = br_target; // RULE5
								extra = BRANCH_TAKEN_EXTRA; // RULE5
							end
						end
					endcase
					if (skip) begin
						s_nxt.pc = s_r.pc + (ex_next_long ? PC_W'(3) : PC_W'(2)); // RULE14
						extra = extra + (ex_next_long ? SKIP_LONG_EXTRA : SKIP_SHORT_EXTRA); // RULE14
					end else if (!ex_next_long && !is_branch(ex_op)) begin
						extra = (ex_op == OP_IOBIT_CLR_SKIP || ex_op == OP_IOBIT_SET_SKIP ||
								ex_op == OP_DIRECT_LOAD || ex_op == OP_IND_LOAD_DEC) ? extra : 2'h0;
					end
					if (extra != 2'h0) begin
						s_nxt.st = ST_WAIT;
						s_nxt.cnt = extra;
						s_nxt.rdy = 1'b0;
					end else if (s_nxt.st == ST_LOAD) begin
						s_nxt.rdy = 1'b0;
					end
				end
			end
			ST_WAIT: begin
				if (s_r.cnt == 2'h1) begin
					if (s_r.load_pend) begin
						s_nxt.st = ST_LOAD;
						s_nxt.mem_req = 1'b1;
					end else begin
						s_nxt.st = ST_IDLE;
						s_nxt.rdy = s_nxt.en;
					end
				end else begin
					s_nxt.cnt = s_r.cnt - 2'h1;
				end
			end
			ST_LOAD: begin
				// memory wait states stretch the load beyond its nominal count
				if (mem_ack) begin
					s_nxt.mem_req = 1'b0;
					s_nxt.rf_we = 1'b1;
					s_nxt.rf_data = mem_rdata;
					if (s_r.ptr_inc) begin
						s_nxt.ptr_we = 1'b1;
						s_nxt.ptr_data = s_r.mem_addr + 16'h0001; // RULE12
					end
					s_nxt.st = ST_IDLE;
					s_nxt.rdy = s_nxt.en;
				end
			end
			default: s_nxt.st = ST_IDLE;
		endcase
	end

	// ----------------------------------------
	// registers
	// ----------------------------------------
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			rstn_meta_r <= 1'b0;
			rstn_sync_r <= 1'b0;
		end else begin
			rstn_meta_r <= 1'b1;
			rstn_sync_r <= rstn_meta_r;
		end
	end

	always_ff @(posedge clock or negedge rstn_sync_r) begin
		if (!rstn_sync_r) begin
			s_r <= '0;
			s_r.flags <= FLAGS_RST;
			s_r.en <= CTRL_EN_RST;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ex_ready = s_r.rdy;
	assign pc = s_r.pc;
	assign status_flags = s_r.flags;
	assign rf_we = s_r.rf_we;
	assign rf_idx = s_r.rf_idx;
	assign rf_data = s_r.rf_data;
	assign ptr_we = s_r.ptr_we;
	assign ptr_data = s_r.ptr_data;
	assign mem_req = s_r.mem_req;
	assign mem_addr = s_r.mem_addr;
	assign s_axi_awready = s_r.awready;
	assign s_axi_wready = s_r.wready;
	assign s_axi_bresp = s_r.bresp;
	assign s_axi_bvalid = s_r.bvalid;
	assign s_axi_arready = s_r.arready;
	assign s_axi_rdata = s_r.rdata;
	assign s_axi_rresp = s_r.rresp;
	assign s_axi_rvalid = s_r.rvalid;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rstn_sync_r);

	property p_eq_skip;
		take && ex_op == OP_EQ_SKIP && rd_data == rr_data && !ex_next_long
			|=> !ex_ready ##1 ex_ready && pc == $past(pc, 2) + PC_W'(2);
	endproperty
	a_eq_skip: assert property (p_eq_skip) else $error("equal skip wrong"); // RULE1
	property p_cmp;
		take && ex_op == OP_CMP |=> ex_ready && status_flags[FLAG_Z] == ($past(rd_data) ==
			$past(rr_data)) && pc == $past(pc) + PC_W'(1);
	endproperty
	a_cmp: assert property (p_cmp) else $error("compare wrong"); // RULE2
	property p_rbit_long;
		take && ex_op == OP_RBIT_SET_SKIP && rr_data[ex_sel] && ex_next_long
			|=> !ex_ready [*2] ##1 ex_ready && pc == $past(pc, 3) + PC_W'(3);
	endproperty
	a_rbit_long: assert property (p_rbit_long) else $error("long skip wrong"); // RULE14
	property p_io_noskip;
		take && ex_op == OP_IOBIT_CLR_SKIP && io_data[ex_sel] |=> !ex_ready ##1 ex_ready;
	endproperty
	a_io_noskip: assert property (p_io_noskip) else $error("io skip timing wrong"); // RULE4
	property p_branch;
		take && is_branch(ex_op) && branch_taken(ex_op, ex_sel, status_flags)
			|=> !ex_ready && pc == $past(br_target) ##1 ex_ready;
	endproperty
	a_branch: assert property (p_branch) else $error("taken branch wrong"); // RULE5
	property p_ge;
		take && ex_op == OP_GE_BR && (status_flags[FLAG_N] ^ status_flags[FLAG_V])
			|=> ex_ready && pc == $past(pc) + PC_W'(1) && status_flags == $past(status_flags);
	endproperty
	a_ge: assert property (p_ge) else $error("signed branch wrong"); // RULE7
	property p_irq;
		take && ex_op == OP_IE_BR && !status_flags[FLAG_I] |=> pc == $past(pc) + PC_W'(1);
	endproperty
	a_irq: assert property (p_irq) else $error("irq branch wrong"); // RULE10
	property p_inc;
		s_r.st == ST_LOAD && mem_ack && s_r.ptr_inc
			|=> rf_we && ptr_we && ptr_data == $past(mem_addr) + 16'h0001;
	endproperty
	a_inc: assert property (p_inc) else $error("post increment wrong"); // RULE12
	property p_dec;
		take && ex_op == OP_IND_LOAD_DEC |=> ptr_we && !mem_req ##1
			mem_req && mem_addr == $past(ex_ptr, 2) - 16'h0001;
	endproperty
	a_dec: assert property (p_dec) else $error("pre decrement wrong"); // RULE13
	property p_direct;
		take && ex_op == OP_DIRECT_LOAD |=> !mem_req ##1 mem_req && mem_addr == $past(ex_addr, 2);
	endproperty
	a_direct: assert property (p_direct) else $error("direct load wrong"); // RULE11

	c_branch: cover property (take && ex_op == OP_LT_BR);
	c_long_io: cover property (take && ex_op == OP_IOBIT_SET_SKIP && ex_next_long);
	c_load: cover property (s_r.st == ST_LOAD && mem_ack && s_r.ptr_inc);
endmodule : branch_skip_compare_exec
`default_nettype wire

// *** design/bsc_pkg.sv ***
// shared constants and types for the branch, skip, compare and load execution unit
package bsc_pkg;
	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] OFS_CTRL = 4'h0;
	localparam logic [3:0] OFS_FLAGS = 4'h4;
	localparam logic [3:0] OFS_PC = 4'h8;
	localparam logic [3:0] OFS_STATE = 4'hC;
	localparam int CTRL_EN_BIT = 0;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic CTRL_EN_RST = 1'b0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ----------------------------------------
	// status flag positions
	// ----------------------------------------
	localparam int FLAG_C = 0;
	localparam int FLAG_Z = 1;
	localparam int FLAG_N = 2;
	localparam int FLAG_V = 3;
	localparam int FLAG_S = 4;
	localparam int FLAG_H = 5;
	localparam int FLAG_T = 6;
	localparam int FLAG_I = 7;
	// ----------------------------------------
	// extra cycles beyond the first
	// ----------------------------------------
	localparam logic [1:0] SKIP_SHORT_EXTRA = 2'h1;
	localparam logic [1:0] SKIP_LONG_EXTRA = 2'h2;
	localparam logic [1:0] IO_SKIP_ADD = 2'h1;
	localparam logic [1:0] BRANCH_TAKEN_EXTRA = 2'h1;
	localparam logic [1:0] DIRECT_LOAD_EXTRA = 2'h1;
	localparam logic [1:0] DEC_LOAD_EXTRA = 2'h1;
	// ----------------------------------------
	// operation codes from fetch
	// ----------------------------------------
	typedef enum logic [4:0] {
		OP_EQ_SKIP = 5'h00, OP_CMP = 5'h01, OP_CMP_C = 5'h02, OP_CMP_I = 5'h03,
		OP_RBIT_CLR_SKIP = 5'h04, OP_RBIT_SET_SKIP = 5'h05,
		OP_IOBIT_CLR_SKIP = 5'h06, OP_IOBIT_SET_SKIP = 5'h07,
		OP_FLAG_SET_BR = 5'h08, OP_FLAG_CLR_BR = 5'h09, OP_EQ_BR = 5'h0A, OP_NE_BR = 5'h0B,
		OP_CS_BR = 5'h0C, OP_CC_BR = 5'h0D, OP_SH_BR = 5'h0E, OP_LO_BR = 5'h0F,
		OP_MI_BR = 5'h10, OP_PL_BR = 5'h11, OP_GE_BR = 5'h12, OP_LT_BR = 5'h13,
		OP_HS_BR = 5'h14, OP_HC_BR = 5'h15, OP_TS_BR = 5'h16, OP_TC_BR = 5'h17,
		OP_VS_BR = 5'h18, OP_VC_BR = 5'h19, OP_IE_BR = 5'h1A, OP_ID_BR = 5'h1B,
		OP_DIRECT_LOAD = 5'h1C, OP_IND_LOAD = 5'h1D,
		OP_IND_LOAD_INC = 5'h1E, OP_IND_LOAD_DEC = 5'h1F
	} op_t;
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_WAIT = 2'h1,
		ST_LOAD = 2'h2
	} state_t;
endpackage : bsc_pkg

// *** tb/data_space_model.sv ***
// data space model that answers read requests after a chosen delay
`timescale 1ns/100ps
`default_nettype none
module data_space_model (
	// clock and reset
	input wire logic clock,
	input wire logic rstn,
	// read port
	input wire logic mem_req,
	input wire logic [15:0] mem_addr,
	input wire logic [1:0] delay,
	output logic mem_ack,
	output logic [7:0] mem_rdata
);
	logic [1:0] cnt_r;
	// outside an answer the data toggles, so a sample one cycle late does not match
	always_ff @(posedge clock or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 2'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 8'h00;
		end else if (mem_req && !mem_ack && cnt_r == delay) begin
			cnt_r <= 2'h0;
			mem_ack <= 1'b1;
			mem_rdata <= mem_addr[7:0] ^ 8'h5A;
		end else begin
			cnt_r <= (mem_req && !mem_ack) ? cnt_r + 2'h1 : 2'h0;
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
		end
	end
endmodule : data_space_model
`default_nettype wire

// *** tb/branch_skip_compare_exec_test.sv ***
// self-checking bench for the branch, skip, compare and load execution unit
`timescale 1ns/100ps
`default_nettype none
module branch_skip_compare_exec_test import bsc_pkg::*;;
	logic clock, rstn, ex_valid, ex_next_long, ex_ready, rf_we, ptr_we, mem_req, mem_ack;
	logic [4:0] ex_op, ex_rd_idx, rf_idx, got_idx;
	logic [2:0] ex_sel;
	logic [6:0] ex_offset;
	logic [7:0] ex_imm, rd_data, rr_data, io_data, status_flags, rf_data, mem_rdata, got_data, v;
	logic [15:0] ex_addr, ex_ptr, pc, ptr_data, mem_addr, got_addr, got_ptr;
	logic [1:0] delay, rsp, s_axi_bresp, s_axi_rresp;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, t;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [3:0] s_axi_wstrb;
	int error_cnt, cmp_count, n, ptr_n, pn0;
	logic [4:0] sk[5] = '{OP_EQ_SKIP, OP_RBIT_CLR_SKIP, OP_RBIT_SET_SKIP, OP_IOBIT_CLR_SKIP,
		OP_IOBIT_SET_SKIP};
	logic [4:0] ld[4] = '{OP_IND_LOAD_INC, OP_IND_LOAD_DEC, OP_DIRECT_LOAD, OP_IND_LOAD};
	logic [15:0] la[4] = '{16'h1234, 16'h1233, 16'h2345, 16'h1234};
	logic [39:0] cmpv[3] = '{40'h01102000_15, 40'h03800140_78, 40'h021010C2_C2};

	branch_skip_compare_exec dut (.*);
	data_space_model mem (.*);

	initial begin
		clock = 1'b0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock) begin
		if (rf_we) begin
			got_idx <= rf_idx;
			got_data <= rf_data;
		end
		if (ptr_we) begin
			got_ptr <= ptr_data;
			ptr_n <= ptr_n + 1;
		end
		if (mem_req) got_addr <= mem_addr;
	end

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		$display("errors %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : summarize
	// address and data offered together, each released on its own handshake
	task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clock);
		s_axi_awaddr <= {4'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		rsp = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a);
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (s_axi_rvalid !== 1'b1);
		rd = s_axi_rdata;
		rsp = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	task automatic setup(input logic [7:0] f);
		axi_wr(OFS_PC, 32'h100);
		axi_wr(OFS_FLAGS, {24'h0, f});
	endtask : setup
	// n counts the cycles with ex_ready low after the instruction is taken
	task automatic exec(input logic [4:0] op);
		@(posedge clock);
		ex_op <= op;
		ex_valid <= 1'b1;
		do @(posedge clock); while (ex_ready !== 1'b1);
		ex_valid <= 1'b0;
		n = 0;
		@(posedge clock);
		while (ex_ready !== 1'b1) begin
			n++;
			@(posedge clock);
		end
		#1;
	endtask : exec
	function automatic logic taken(input logic [4:0] op, input logic [7:0] f);
		logic b;
		logic [4:0] p;
		p = (op - 5'h0A) >> 1;
		case (p)
			5'h0: b = f[FLAG_Z];
			5'h1, 5'h2: b = f[FLAG_C];
			5'h3: b = f[FLAG_N];
			5'h4: b = f[FLAG_N] ^ f[FLAG_V];
			5'h5: b = f[FLAG_H];
			5'h6: b = f[FLAG_T];
			5'h7: b = f[FLAG_V];
			5'h8: b = f[FLAG_I];
			default: b = f[op[2:0]];
		endcase
		// same-or-higher, lower and the signed pair run opposite to the bit order
		b = op[0] ^ b ^ (p == 5'h2 || p == 5'h4);
		return b;
	endfunction : taken

	initial begin
		{ex_valid, ex_next_long, ex_op, ex_rd_idx, ex_sel, ex_offset, ex_imm} = '0;
		{rd_data, rr_data, io_data, ex_addr, ex_ptr, delay} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		{error_cnt, cmp_count, ptr_n} = '0;
		rstn = 1'b0;
		repeat (5) @(posedge clock);
		rstn <= 1'b1;
		repeat (4) @(posedge clock);
		check(ex_ready, 0);
		axi_wr(OFS_CTRL, 32'h1);
		check(rsp, RESP_OKAY);
		axi_rd({4'h0, OFS_CTRL});
		check(rd, 32'h1);
		axi_rd(8'h10);
		check(rd, 32'h0);
		check(rsp, RESP_SLVERR);
		// ----------------------------------------
		// compares: {op, rd, rr or immediate, flags before} and flags after
		// ----------------------------------------
		foreach (cmpv[i]) begin
			setup(cmpv[i][15:8]);
			rd_data <= cmpv[i][31:24];
			rr_data <= cmpv[i][23:16];
			ex_imm <= cmpv[i][23:16];
			exec({3'h0, cmpv[i][33:32]});
			check({status_flags, n[7:0], pc}, {cmpv[i][7:0], 8'h0, 16'h101});
		end
		// ----------------------------------------
		// every branch against three flag patterns
		// ----------------------------------------
		foreach (sk[fi]) if (fi < 3) for (int op = 8; op < 28; op++) begin
			v = fi == 0 ? 8'h00 : (fi == 1 ? 8'h55 : 8'hAA);
			setup(v);
			ex_sel <= op[2:0];
			ex_offset <= op[0] ? 7'h7C : 7'h05;
			exec(5'(op));
			t = taken(5'(op), v);
			check(pc, 16'(16'h101 + (t ? (op[0] ? 16'hFFFC : 16'h5) : 16'h0)));
			check({status_flags, 7'h0, n[0]}, {v, 7'h0, t});
		end
		// ----------------------------------------
		// skips: match or not, next one or two words
		// ----------------------------------------
		foreach (sk[i]) for (int k = 0; k < 4; k++) begin
			v = k[0] ? 8'hF7 : 8'h08;
			setup(8'hAA);
			rd_data <= v;
			rr_data <= i == 0 ? 8'h08 : v;
			io_data <= v;
			ex_sel <= 3'h3;
			ex_next_long <= k[1];
			exec(sk[i]);
			t = i == 0 ? v == 8'h08 : sk[i][0] == v[3];
			check(pc, 16'h100 + (t ? (k[1] ? 3 : 2) : 1));
			check(n, (t ? (k[1] ? 2 : 1) : 0) + (i > 2));
			check(status_flags, 8'hAA);
		end
		// ----------------------------------------
		// loads with quick and slow data space answers
		// ----------------------------------------
		foreach (ld[i]) begin
			setup(8'h55);
			pn0 = ptr_n;
			ex_ptr <= 16'h1234;
			ex_addr <= 16'h2345;
			ex_rd_idx <= 5'(i + 3);
			delay <= 2'(i * 3);
			exec(ld[i]);
			check({got_addr, got_data}, {la[i], la[i][7:0] ^ 8'h5A});
			check({got_idx, status_flags}, {5'(i + 3), 8'h55});
			check(ptr_n - pn0, i < 2);
			if (i < 2) check(got_ptr, i == 0 ? 16'h1235 : 16'h1233);
		end
		axi_wr(OFS_CTRL, 32'h0);
		repeat (3) @(posedge clock);
		check(ex_ready, 0);
		summarize();
	end
	initial begin
		#400000;
		error_cnt++;
		summarize();
	end
endmodule : branch_skip_compare_exec_test
`default_nettype wire
